// ==== design/pfce_fill.sv ====
// pattern fill engine: fetch, colour-expand and tile an 8x8 pattern
`timescale 1ns/10ps
`include "pfce_map.svh"
module pfce_fill #(
  parameter int DIM_W = 16
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                cmd_valid_i,
  output logic                     cmd_ready_o,
  input  wire logic [7:0]          cmd_opcode_i,
  input  wire logic [7:0]          cmd_rop_i,
  input  wire logic [31:0]         cmd_dst_addr_i,
  input  wire logic [DIM_W-1:0]    cmd_pitch_i,
  input  wire logic [DIM_W-1:0]    cmd_width_i,
  input  wire logic [DIM_W-1:0]    cmd_height_i,
  input  wire logic [31:0]         cmd_pat_addr_i,
  input  wire logic                cmd_pat_stream_i,
  input  wire logic [2:0]          cmd_vert_align_i,
  input  wire logic                cmd_dyn_color_en_i,
  input  wire pfce_pkg::pfce_depth_t cmd_dyn_depth_i,
  input  wire logic [2:0]          cmd_transp_mode_i,
  input  wire logic [63:0]         cmd_mono_pat_i,
  input  wire logic [31:0]         pat_fg_i,
  input  wire logic [31:0]         pat_bg_i,
  input  wire pfce_pkg::pfce_depth_t cfg_depth_i,
  input  wire logic                pat_valid_i,
  output logic                     pat_ready_o,
  input  wire logic [63:0]         pat_data_i,
  output logic                     rd_req_o,
  output logic [31:0]              rd_addr_o,
  input  wire logic                rd_ack_i,
  input  wire logic [63:0]         rd_data_i,
  output logic                     wr_req_o,
  output logic [31:0]              wr_addr_o,
  output logic [31:0]              wr_data_o,
  output pfce_pkg::pfce_depth_t    wr_size_o,
  input  wire logic                wr_ack_i,
  output logic                     src_read_o,
  output logic                     busy_o,
  output logic                     done_o
);

  import pfce_pkg::*;

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (DIM_W < 4 || DIM_W > 32)
  begin : g_chk
    $error("pfce_fill: DIM_W must be 4 to 32");
  end

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic logic is_mono(input logic [7:0] op);
    is_mono = op[`PFCE_OPC_MONO_BIT];
  endfunction : is_mono

  // pattern used when the result depends on p
  function automatic logic rop_uses_pat(input logic [7:0] rop);
    rop_uses_pat = (rop[7:4] != rop[3:0]);
  endfunction : rop_uses_pat

  // source used when the result depends on s
  function automatic logic rop_uses_src(input logic [7:0] rop);
    rop_uses_src = ({rop[7:6], rop[3:2]} != {rop[5:4], rop[1:0]});
  endfunction : rop_uses_src

  function automatic logic [31:0] depth_mask(input pfce_depth_t d);
    if (d == `PFCE_DEPTH_8)
      depth_mask = 32'h0000_00ff;
    else if (d == `PFCE_DEPTH_16)
      depth_mask = 32'h0000_ffff;
    else
      depth_mask = 32'hffff_ffff;
  endfunction : depth_mask

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pfce_state_t      st_reg;
  logic             mono_reg;
  logic [7:0]       rop_reg;
  pfce_depth_t      depth_reg;
  logic [2:0]       transp_reg;
  logic [63:0]      mono_pat_reg;
  logic [31:0]      fg_reg;
  logic [31:0]      bg_reg;
  logic [31:0]      pat_base_reg;
  logic [31:0]      line_addr_reg;
  logic [DIM_W-1:0] pitch_reg;
  logic [DIM_W-1:0] width_reg;
  logic [DIM_W-1:0] lines_left_reg;
  logic [DIM_W-1:0] x_byte_reg;
  logic [2:0]       row_reg;
  logic [2:0]       col_reg;
  logic [5:0]       qw_cnt_reg;
  logic [5:0]       qw_total_reg;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire              cmd_take    = cmd_valid_i & cmd_ready_o;
  wire              cmd_mono    = is_mono(cmd_opcode_i);
  wire              cmd_pat_use = rop_uses_pat(cmd_rop_i);
  wire              cmd_empty   = (cmd_width_i == '0) || (cmd_height_i == '0);
  wire pfce_depth_t cmd_depth   = cmd_dyn_color_en_i ? cmd_dyn_depth_i
                                                     : cfg_depth_i;
  // quadwords per colour pattern: 8, 16 or 32
  wire [5:0]        cmd_qw_total = `PFCE_PAT_QW_8BPP << cmd_depth;
  wire              cmd_fetch   = cmd_pat_use & ~cmd_mono;

  // ----------------------------------------------------------------
  // pattern store
  // ----------------------------------------------------------------
  wire [7:0]  pix_bytes = 8'h01 << depth_reg;
  // byte offset of pixel (row, col) inside the colour pattern
  wire [7:0]  pat_off   = 8'({row_reg, col_reg}) << depth_reg;
  wire [4:0]  pat_qw    = pat_off[7:3];
  wire [2:0]  pat_lane  = pat_off[2:0];
  wire [63:0] mem_rdata;
  wire        fetch_acc = rd_req_o & rd_ack_i;
  wire        strm_acc  = pat_valid_i & pat_ready_o;
  wire        mem_we    = fetch_acc | strm_acc;
  wire [63:0] mem_wdata = fetch_acc ? rd_data_i : pat_data_i;
  wire        last_qw   = (qw_cnt_reg + 6'h01 == qw_total_reg);

  pfce_pat_mem #(
    .WIDTH (64),
    .DEPTH (`PFCE_PAT_QW_MAX),
    .AW    (5)
  ) u_pat_mem (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .wr_en_i    (mem_we),
    .wr_addr_i  (qw_cnt_reg[4:0]),
    .wr_data_i  (mem_wdata),
    .rd_addr_i  (pat_qw),
    .rd_data_o  (mem_rdata)
  );

  // ----------------------------------------------------------------
  // pixel formation
  // ----------------------------------------------------------------
  wire [63:0] lane_shift = mem_rdata >> {pat_lane, 3'h0};
  wire        mono_bit   = mono_pat_reg[{row_reg, ~col_reg}];
  wire [31:0] mono_col   = mono_bit ? fg_reg : bg_reg;
  wire [31:0] pat_pix    = mono_reg ? mono_col : lane_shift[31:0];
  // with no source and no destination read the rop reduces to its p term
  wire [31:0] rop_pix    = (pat_pix & {32{rop_reg[`PFCE_ROP_P1_BIT]}})
                         | (~pat_pix & {32{rop_reg[`PFCE_ROP_P0_BIT]}});
  wire [31:0] out_pix    = rop_pix & depth_mask(depth_reg);
  // nonzero transparency leaves mono background pixels untouched
  wire        pix_write  = (transp_reg == `PFCE_TRANSP_OFF)
                         | ~mono_reg | mono_bit;

  // ----------------------------------------------------------------
  // walk
  // ----------------------------------------------------------------
  wire [DIM_W-1:0] x_byte_nx = x_byte_reg + DIM_W'(pix_bytes);
  wire             line_end  = (x_byte_nx >= width_reg);
  wire             last_line = (lines_left_reg == DIM_W'(1));
  wire [31:0]      pix_addr  = line_addr_reg + 32'(x_byte_reg);
  wire [31:0]      next_line = line_addr_reg + 32'(pitch_reg);

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_reg         <= PFCE_S_IDLE;
      cmd_ready_o    <= 1'b0;
      pat_ready_o    <= 1'b0;
      rd_req_o       <= 1'b0;
      rd_addr_o      <= `PFCE_RST_WORD;
      wr_req_o       <= 1'b0;
      wr_addr_o      <= `PFCE_RST_WORD;
      wr_data_o      <= `PFCE_RST_WORD;
      wr_size_o      <= `PFCE_DEPTH_8;
      src_read_o     <= 1'b0;
      busy_o         <= 1'b0;
      done_o         <= 1'b0;
      mono_reg       <= 1'b0;
      rop_reg        <= 8'h00;
      depth_reg      <= `PFCE_DEPTH_8;
      transp_reg     <= `PFCE_TRANSP_OFF;
      mono_pat_reg   <= `PFCE_RST_QWORD;
      fg_reg         <= `PFCE_RST_WORD;
      bg_reg         <= `PFCE_RST_WORD;
      pat_base_reg   <= `PFCE_RST_WORD;
      line_addr_reg  <= `PFCE_RST_WORD;
      pitch_reg      <= '0;
      width_reg      <= '0;
      lines_left_reg <= '0;
      x_byte_reg     <= '0;
      row_reg        <= 3'h0;
      col_reg        <= 3'h0;
      qw_cnt_reg     <= 6'h00;
      qw_total_reg   <= 6'h00;
    end
    else
    begin
      done_o <= 1'b0;
      case (st_reg)
        PFCE_S_IDLE:
        begin
          cmd_ready_o <= 1'b1;
          if (cmd_take)
          begin
            cmd_ready_o    <= 1'b0;
            mono_reg       <= cmd_mono;
            rop_reg        <= cmd_rop_i;
            depth_reg      <= cmd_depth;
            transp_reg     <= cmd_transp_mode_i;
            mono_pat_reg   <= cmd_mono_pat_i;
            fg_reg         <= pat_fg_i;
            bg_reg         <= pat_bg_i;
            pat_base_reg   <= {cmd_pat_addr_i[31:3], 3'h0};
            line_addr_reg  <= cmd_dst_addr_i;
            pitch_reg      <= cmd_pitch_i;
            width_reg      <= cmd_width_i;
            lines_left_reg <= cmd_height_i;
            x_byte_reg     <= '0;
            row_reg        <= cmd_vert_align_i;
            col_reg        <= 3'h0;
            qw_cnt_reg     <= 6'h00;
            qw_total_reg   <= cmd_qw_total;
            src_read_o     <= rop_uses_src(cmd_rop_i);
            if (cmd_empty)
            begin
              cmd_ready_o <= 1'b1;
              done_o      <= 1'b1;
            end
            else
            begin
              busy_o <= 1'b1;
              if (cmd_fetch && cmd_pat_stream_i)
              begin
                pat_ready_o <= 1'b1;
                st_reg      <= PFCE_S_STREAM;
              end
              else if (cmd_fetch)
              begin
                rd_req_o  <= 1'b1;
                rd_addr_o <= {cmd_pat_addr_i[31:3], 3'h0};
                st_reg    <= PFCE_S_FETCH;
              end
              else
              begin
                st_reg <= PFCE_S_RADDR;
              end
            end
          end
        end
        PFCE_S_FETCH:
        begin
          if (fetch_acc)
          begin
            qw_cnt_reg <= qw_cnt_reg + 6'h01;
            rd_addr_o  <= rd_addr_o + 32'h0000_0008;
            if (last_qw)
            begin
              rd_req_o <= 1'b0;
              st_reg   <= PFCE_S_RADDR;
            end
          end
        end
        PFCE_S_STREAM:
        begin
          if (strm_acc)
          begin
            qw_cnt_reg <= qw_cnt_reg + 6'h01;
            if (last_qw)
            begin
              pat_ready_o <= 1'b0;
              st_reg      <= PFCE_S_RADDR;
            end
          end
        end
        PFCE_S_RADDR:
        begin
          // pattern store read address settles this cycle
          st_reg <= PFCE_S_PIX;
        end
        PFCE_S_PIX:
        begin
          wr_addr_o <= pix_addr;
          wr_data_o <= out_pix;
          wr_size_o <= depth_reg;
          if (pix_write)
          begin
            wr_req_o <= 1'b1;
          end
          st_reg <= PFCE_S_WRITE;
        end
        PFCE_S_WRITE:
        begin
          if (!wr_req_o || wr_ack_i)
          begin
            wr_req_o <= 1'b0;
            st_reg   <= PFCE_S_RADDR;
            if (line_end)
            begin
              x_byte_reg     <= '0;
              col_reg        <= 3'h0;
              row_reg        <= row_reg + 3'h1;
              line_addr_reg  <= next_line;
              lines_left_reg <= lines_left_reg - DIM_W'(1);
              if (last_line)
              begin
                busy_o      <= 1'b0;
                done_o      <= 1'b1;
                cmd_ready_o <= 1'b1;
                st_reg      <= PFCE_S_IDLE;
              end
            end
            else
            begin
              x_byte_reg <= x_byte_nx;
              col_reg    <= col_reg + 3'h1;
            end
          end
        end
        default:
        begin
          st_reg <= PFCE_S_IDLE;
        end
      endcase
    end
  end

endmodule : pfce_fill

// ==== design/pfce_pat_mem.sv ====
// pattern store: one quadword per word, registered read data
`timescale 1ns/10ps
module pfce_pat_mem #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  if ((1 << AW) < DEPTH)
  begin : g_chk
    $error("pfce_pat_mem: address too narrow for depth");
  end

  always_ff @(posedge core_clk_i)
  begin
    if (wr_en_i)
    begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_o <= '0;
    end
    else
    begin
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end

endmodule : pfce_pat_mem

// ==== dv/pfce_fb_model.sv ====
// frame buffer memory and pattern stream producer model
`timescale 1ns/10ps
module pfce_fb_model (
  input  wire logic                  core_clk_i,
  input  wire logic                  rd_req_i,
  input  wire logic [31:0]           rd_addr_i,
  output logic                       rd_ack_o,
  output logic [63:0]                rd_data_o,
  input  wire logic                  wr_req_i,
  input  wire logic [31:0]           wr_addr_i,
  input  wire logic [31:0]           wr_data_i,
  input  wire pfce_pkg::pfce_depth_t wr_size_i,
  output logic                       wr_ack_o,
  output logic                       pat_valid_o,
  input  wire logic                  pat_ready_i,
  output logic [63:0]                pat_data_o
);
  import pfce_pkg::*;
  int          lat = 0;
  int          qn = 0;
  int          sq = 0;
  int          reads = 0;
  int          rc = 0;
  int          wc = 0;
  logic        pv = 1'b0;
  logic        pr = 1'b0;
  logic [31:0] wq_addr[$];
  logic [31:0] wq_data[$];
  pfce_depth_t wq_size[$];
  // linear pattern layout: byte value equals its offset
  function automatic logic [63:0] qword(input int off);
    logic [63:0] q;
    for (int k = 0; k < 8; k++) q[8*k +: 8] = 8'(off + k);
    return q;
  endfunction : qword
  initial
  begin
    rd_ack_o = 1'b0;
    rd_data_o = 64'h0;
    wr_ack_o = 1'b0;
    pat_valid_o = 1'b0;
    pat_data_o = 64'h0;
    forever
    begin
      @(posedge core_clk_i) #1;
      if (rd_ack_o)
      begin
        rd_ack_o = 1'b0;
        rd_data_o = ~rd_data_o;
      end
      else if (rd_req_i && rc < lat) rc++;
      else if (rd_req_i)
      begin
        rd_ack_o = 1'b1;
        rd_data_o = qword(int'(rd_addr_i[7:0]));
        reads++;
        rc = 0;
      end
      if (wr_ack_o) wr_ack_o = 1'b0;
      else if (wr_req_i && wc < lat) wc++;
      else if (wr_req_i)
      begin
        wr_ack_o = 1'b1;
        wc = 0;
        wq_addr.push_back(wr_addr_i);
        wq_data.push_back(wr_data_i);
        wq_size.push_back(wr_size_i);
      end
      if (pv && pr) sq++;
      pat_valid_o = sq < qn;
      pat_data_o = pat_valid_o ? qword(8 * sq) : ~pat_data_o;
      pv = pat_valid_o;
      pr = pat_ready_i;
    end
  end
endmodule : pfce_fb_model

// ==== dv/pfce_fill_checker.sv ====
// port assertions for the pattern fill engine
`timescale 1ns/10ps
`include "pfce_map.svh"
module pfce_fill_checker (
  input wire logic                  core_clk_i,
  input wire logic                  rst_b_i,
  input wire logic                  cmd_valid_i,
  input wire logic                  cmd_ready_o,
  input wire logic [7:0]            cmd_opcode_i,
  input wire logic [7:0]            cmd_rop_i,
  input wire logic [31:0]           cmd_dst_addr_i,
  input wire logic [2:0]            cmd_transp_mode_i,
  input wire logic                  pat_ready_o,
  input wire logic                  rd_req_o,
  input wire logic [31:0]           rd_addr_o,
  input wire logic                  rd_ack_i,
  input wire logic                  wr_req_o,
  input wire logic [31:0]           wr_addr_o,
  input wire logic [31:0]           wr_data_o,
  input wire pfce_pkg::pfce_depth_t wr_size_o,
  input wire logic                  wr_ack_i,
  input wire logic                  src_read_o,
  input wire logic                  busy_o,
  input wire logic                  done_o
);
  import pfce_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------------------------------
  // command tracking
  // ----------------------------------------------------------------
  wire logic take = cmd_valid_i && cmd_ready_o;
  wire logic need_src = {cmd_rop_i[7:6], cmd_rop_i[3:2]} != {cmd_rop_i[5:4], cmd_rop_i[1:0]};
  wire logic no_pat = cmd_opcode_i[`PFCE_OPC_MONO_BIT] || cmd_rop_i[7:4] == cmd_rop_i[3:0];
  logic        nofetch_reg;
  logic        first_reg;
  logic [31:0] dst_reg;
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      nofetch_reg <= 1'b0;
      first_reg <= 1'b0;
      dst_reg <= `PFCE_RST_WORD;
    end
    else if (take)
    begin
      nofetch_reg <= no_pat;
      first_reg <= cmd_transp_mode_i == `PFCE_TRANSP_OFF;
      dst_reg <= cmd_dst_addr_i;
    end
    else
    begin
      if (done_o) nofetch_reg <= 1'b0;
      if (wr_req_o) first_reg <= 1'b0;
    end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_take; cmd_valid_i && cmd_ready_o; endsequence
  sequence s_wr_done; wr_req_o && wr_ack_i; endsequence
  sequence s_wr_gap; !wr_req_o [*2]; endsequence
  cmd_take_a: assert property (s_take |=> (!cmd_ready_o && busy_o) || done_o)
    else $error("taken command did not start");
  done_end_a: assert property (done_o && !cmd_valid_i |->
    cmd_ready_o && !busy_o ##1 !done_o) else $error("done pulse malformed");
  wr_hold_a: assert property (wr_req_o && !wr_ack_i |=> wr_req_o && $stable(wr_addr_o)
    && $stable(wr_data_o) && $stable(wr_size_o)) else $error("write request changed early");
  wr_gap_a: assert property (s_wr_done |=> s_wr_gap) else $error("write too soon after ack");
  wr_mask_a: assert property (wr_req_o |->
    (wr_size_o == `PFCE_DEPTH_8 ? wr_data_o[31:8] == 24'h0
    : wr_size_o != `PFCE_DEPTH_16 || wr_data_o[31:16] == 16'h0))
    else $error("write data unmasked");
  wr_first_a: assert property (first_reg && wr_req_o |-> wr_addr_o == dst_reg)
    else $error("first write not at destination address");
  rd_align_a: assert property (rd_req_o |-> rd_addr_o[2:0] == 3'h0)
    else $error("pattern read not quadword aligned");
  rd_step_a: assert property (rd_req_o && rd_ack_i |=>
    !rd_req_o || rd_addr_o == $past(rd_addr_o) + 32'h8)
    else $error("pattern read address did not step by 8");
  rd_hold_a: assert property (rd_req_o && !rd_ack_i |=> rd_req_o && $stable(rd_addr_o))
    else $error("pattern read request dropped early");
  no_fetch_a: assert property (nofetch_reg |-> !rd_req_o && !pat_ready_o)
    else $error("pattern fetched when not needed");
  src_flag_a: assert property (s_take |=> src_read_o == $past(need_src))
    else $error("source flag wrong");
endmodule : pfce_fill_checker

bind pfce_fill pfce_fill_checker i_chk (.*);

// ==== dv/test_pfce_fill.sv ====
// self-checking bench for the pattern fill engine
`timescale 1ns/10ps
`include "pfce_map.svh"
module test_pfce_fill;
  import pfce_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        cmd_valid_i = 1'b0, cmd_pat_stream_i = 1'b0, cmd_dyn_color_en_i = 1'b0;
  logic [7:0]  cmd_opcode_i = 8'h0, cmd_rop_i = 8'h0;
  logic [15:0] cmd_pitch_i = 16'h0, cmd_width_i = 16'h0, cmd_height_i = 16'h0;
  logic [2:0]  cmd_vert_align_i = 3'h0, cmd_transp_mode_i = `PFCE_TRANSP_OFF;
  pfce_depth_t cmd_dyn_depth_i = `PFCE_DEPTH_8, cfg_depth_i = `PFCE_DEPTH_8;
  logic [31:0] cmd_dst_addr_i = 32'h0002_0080, cmd_pat_addr_i = 32'h0010_0005;
  logic [63:0] cmd_mono_pat_i = 64'h80c1_2418_f00f_a55a;
  logic [31:0] pat_fg_i = 32'h1234_5678, pat_bg_i = 32'h9abc_def0;
  logic        cmd_ready_o, pat_ready_o, rd_req_o, rd_ack_i, wr_req_o, wr_ack_i;
  logic        src_read_o, busy_o, done_o, pat_valid_i;
  logic [31:0] rd_addr_o, wr_addr_o, wr_data_o;
  logic [63:0] rd_data_i, pat_data_i;
  pfce_depth_t wr_size_o;
  int          miscompares = 0, samples_checked = 0;
  always #5 core_clk_i = ~core_clk_i;
  pfce_fill #(.DIM_W(16)) i_dut (.*);
  pfce_fb_model i_fb (.core_clk_i(core_clk_i), .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o),
    .rd_ack_o(rd_ack_i), .rd_data_o(rd_data_i), .wr_req_i(wr_req_o), .wr_addr_i(wr_addr_o),
    .wr_data_i(wr_data_o), .wr_size_i(wr_size_o), .wr_ack_o(wr_ack_i),
    .pat_valid_o(pat_valid_i), .pat_ready_i(pat_ready_o), .pat_data_o(pat_data_i));
  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task check(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // one command, then its writes compared in order
  // ----------------------------------------------------------------
  task run(input logic [7:0] op, rop, input int w, h, p, al, input logic st, dy,
           input pfce_depth_t dd, cf, input int lt);
    int          d, t, r, c, nrd;
    logic [31:0] v, ga, gd;
    logic        b;
    pfce_depth_t gs;
    cmd_opcode_i = op;
    cmd_rop_i = rop;
    cmd_width_i = 16'(w);
    cmd_height_i = 16'(h);
    cmd_pitch_i = 16'(p);
    cmd_vert_align_i = 3'(al);
    cmd_pat_stream_i = st;
    cmd_dyn_color_en_i = dy;
    cmd_dyn_depth_i = dd;
    cfg_depth_i = cf;
    d = dy ? int'(dd) : int'(cf);
    nrd = (op[0] || rop[7:4] == rop[3:0] || st || w * h == 0) ? 0 : 8 << d;
    i_fb.lat = lt;
    i_fb.qn = st ? 8 << d : 0;
    i_fb.sq = 0;
    i_fb.reads = 0;
    cmd_valid_i = 1'b1;
    for (t = 0; t < 50 && cmd_ready_o !== 1'b1; t++) @(posedge core_clk_i) #1;
    @(posedge core_clk_i) #1;
    cmd_valid_i = 1'b0;
    check("busy", 64'(w * h != 0), 64'(busy_o));
    check("early done", 64'(w * h == 0), 64'(done_o));
    check("source flag", 64'({rop[7:6], rop[3:2]} != {rop[5:4], rop[1:0]}),
      64'(src_read_o));
    for (t = 0; t < 20000 && done_o !== 1'b1; t++) @(posedge core_clk_i) #1;
    check("done", 64'h1, 64'(done_o));
    for (r = 0; r < h; r++)
      for (c = 0; c * (1 << d) < w; c++)
      begin
        b = cmd_mono_pat_i[(al + r) % 8 * 8 + 7 - c % 8];
        // transparent mono background pixels are never written
        if (op[0] && !b && cmd_transp_mode_i != `PFCE_TRANSP_OFF) continue;
        if (op[0]) v = b ? pat_fg_i : pat_bg_i;
        else
          for (int k = 0; k < 4; k++)
            v[8*k +: 8] = 8'((((al + r) % 8) * 8 + c % 8) * (1 << d) + k);
        v = ((v & {32{rop[4]}}) | (~v & {32{rop[0]}})) & (32'hffff_ffff >> (32 - (8 << d)));
        ga = i_fb.wq_addr.size() ? i_fb.wq_addr.pop_front() : 'x;
        gd = i_fb.wq_data.size() ? i_fb.wq_data.pop_front() : 'x;
        gs = i_fb.wq_size.size() ? i_fb.wq_size.pop_front() : 'x;
        check("write address", 64'(cmd_dst_addr_i + r * p + c * (1 << d)), 64'(ga));
        check("write data", 64'(v), 64'(gd));
        check("write size", 64'(d), 64'(gs));
      end
    check("extra writes", 64'h0, 64'(i_fb.wq_addr.size()));
    check("pattern reads", 64'(nrd), 64'(i_fb.reads));
    i_fb.wq_addr.delete();
    i_fb.wq_data.delete();
    i_fb.wq_size.delete();
    cmd_dst_addr_i += 32'h0001_0000;
    cmd_pat_addr_i[2:0] += 3'h1;
    cmd_mono_pat_i = {cmd_mono_pat_i[0], cmd_mono_pat_i[63:1]};
    pat_fg_i = ~pat_fg_i;
  endtask : run
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    #200000;
    miscompares++;
    $display("[FAIL] watchdog expected done seen timeout");
    conclude;
  end
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    #1;
    check("reset outputs", 64'h0, 64'({cmd_ready_o, busy_o, done_o, rd_req_o, wr_req_o,
      pat_ready_o, src_read_o}));
    repeat (7) @(posedge core_clk_i);
    #1;
    rst_b_i = 1'b1;
    run(`PFCE_OPC_FILL_COLOR, `PFCE_ROP_PAT_COPY, 10, 10, 16, 0, 0, 0, 0, 0, 0);
    run(`PFCE_OPC_XY_COLOR, `PFCE_ROP_PAT_COPY, 20, 9, 24, 3, 1, 0, 0, 1, 2);
    run(`PFCE_OPC_FILL_COLOR, `PFCE_ROP_PAT_COPY, 36, 2, 40, 7, 0, 1, 2, 0, 1);
    run(`PFCE_OPC_FILL_MONO, `PFCE_ROP_PAT_COPY, 9, 9, 12, 5, 0, 1, 0, 2, 0);
    run(`PFCE_OPC_XY_MONO, `PFCE_ROP_PAT_COPY, 16, 3, 16, 0, 0, 0, 0, 1, 3);
    cmd_transp_mode_i = 3'h2;
    run(`PFCE_OPC_FILL_MONO, `PFCE_ROP_PAT_COPY, 12, 3, 12, 1, 0, 0, 0, 0, 1);
    cmd_transp_mode_i = `PFCE_TRANSP_OFF;
    run(`PFCE_OPC_FILL_COLOR, `PFCE_ROP_SRC_COPY, 8, 2, 8, 0, 0, 0, 0, 0, 0);
    run(`PFCE_OPC_FILL_COLOR, `PFCE_ROP_PAT_COPY, 0, 4, 8, 0, 0, 0, 0, 0, 0);
    conclude;
  end
endmodule : test_pfce_fill

// ==== shared/pfce_map.svh ====
// field codes, pattern geometry and reset values for the pattern fill engine
`ifndef PFCE_MAP_SVH
`define PFCE_MAP_SVH

// ----------------------------------------------------------------
// colour depth codes (engine and dynamic depth field)
// ----------------------------------------------------------------
`define PFCE_DEPTH_8          2'h0
`define PFCE_DEPTH_16         2'h1
`define PFCE_DEPTH_32         2'h2

// ----------------------------------------------------------------
// command opcodes; bit 0 marks a monochrome pattern
// ----------------------------------------------------------------
`define PFCE_OPC_FILL_COLOR   8'h40
`define PFCE_OPC_FILL_MONO    8'h41
`define PFCE_OPC_XY_COLOR     8'h50
`define PFCE_OPC_XY_MONO      8'h51
`define PFCE_OPC_MONO_BIT     0

// ----------------------------------------------------------------
// raster operation codes and bit positions
// ----------------------------------------------------------------
`define PFCE_ROP_PAT_COPY     8'hf0
`define PFCE_ROP_SRC_COPY     8'hcc
`define PFCE_ROP_P0_BIT       0
`define PFCE_ROP_P1_BIT       4

// ----------------------------------------------------------------
// pattern geometry
// ----------------------------------------------------------------
`define PFCE_PAT_DIM          8
`define PFCE_PAT_MAX_BYTES    256
`define PFCE_PAT_QW_8BPP      6'h08
`define PFCE_QW_SHIFT         3
`define PFCE_PAT_QW_MAX       32

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PFCE_RST_WORD         32'h0000_0000
`define PFCE_RST_QWORD        64'h0000_0000_0000_0000
`define PFCE_TRANSP_OFF       3'h0

`endif

// ==== shared/pfce_pkg.sv ====
// types shared by the pattern fill engine files
package pfce_pkg;

  typedef logic [1:0] pfce_depth_t;

  typedef enum logic [2:0] {
    PFCE_S_IDLE,
    PFCE_S_FETCH,
    PFCE_S_STREAM,
    PFCE_S_RADDR,
    PFCE_S_PIX,
    PFCE_S_WRITE
  } pfce_state_t;

endpackage : pfce_pkg
